// File: logic/twc_top.sv
// Two-wire bus master and slave controller with a Wishbone register port
// Notes on behaviour
// - Master clock is clock over 2*(reload+2)
// - Set mask bits ignore address bits
// - Masking works only with strict bit clear
// - Reserved patterns give a masked match only as ten-bit upper byte
// - General call acknowledged only when accepted
// - 11110xx matches only as ten-bit upper byte
// - Module on owns pins; off releases them
// - Idle halt stops the block in idle
// - Clock release forced high at reset, off
// - Release frees clock; zero holds it low
// - Hardware clears release at transmit, and at receive only with stretch allow
// - Strict: slave refuses reserved addresses
// - Not strict: slave acknowledges reserved addresses
// - Ten-bit select widens own address
// - Slew off bit drives slew control output
// - SMBus level bit drives input threshold output
// - Repeater option accepts every address
// - Go bits make condition, cleared when done
// - Receive go reads one byte, then clears
// - Ack value one sends NACK, zero ACK
// - Stretch allow selects release behaviour
`timescale 1ns/100ps
`include "twc_cfg.svh"
module twc_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             scl_o,
   output logic             scl_oe_n_o,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   // System
   input  wire logic        idle_i,
   output logic             pins_owned_o,
   output logic             slew_off_o,
   output logic             smbus_lvl_o
);
   logic [15:0] ctrl;
   logic [15:0] next_ctrl;
   logic [9:0]  own;
   logic [9:0]  msk;
   logic [15:0] rate;
   logic [7:0]  txd;
   logic [7:0]  rxd;
   logic        repeater;
   logic        rx_full;
   logic        ackstat;
   logic        ovf;
   logic        wcol;
   logic        gc_seen;
   logic        ten_seen;
   logic        bus_busy;
   logic        tx_pend;
   logic        scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
   logic        scl_rise, scl_fall, start_det, stop_det;
   logic        run, wb_req, wr, rd;
   logic [15:0] rd_val;
   twc_pkg::twc_mst_type m_st, m_nx;
   logic [4:0]  m_step;
   logic [7:0]  m_sh;
   logic        m_scl_low, m_sda_low, m_own, m_go, m_last, m_fin;
   twc_pkg::twc_slv_type s_st;
   logic [3:0]  s_cnt;
   logic [7:0]  s_sh;
   logic        s_sda_low, s_rw, s_nack, s_pair, s_second;
   logic        s_scl_low, s_sda_drv, s_txbeg, s_rxend, acc1, acc2, gcall;
   logic [6:0]  s_a;

   twc_div_if dv ();
   twc_rate_div u_div (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .dv    (dv)
   );

   function automatic logic [15:0] lane(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [3:0]  sel);
      lane = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
   endfunction

   function automatic logic rsv(input logic [6:0] a);
      rsv = (a[6:3] == 4'h0) || (a[6:3] == 4'hF);
   endfunction

   // Masked compare; strict mode turns the mask off
   function automatic logic meq(input logic [9:0] a, input logic [9:0] b,
                                input logic [9:0] m, input logic strict);
      meq = ((a ^ b) & ~(strict ? 10'h0 : m)) == 10'h0;
   endfunction

   // Pins come from another domain: two flops before any use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {scl_m, scl_s, scl_p} <= 3'h7;
         {sda_m, sda_s, sda_p} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
      end
   end
   assign scl_rise  = scl_s & ~scl_p;
   assign scl_fall  = ~scl_s & scl_p;
   assign start_det = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
   assign run = ctrl[`TWC_B_ON] & ~(ctrl[`TWC_B_SIDL] & idle_i);

   // Wishbone: ack one cycle after the strobe, unmapped reads give zero
   assign wb_req = cyc_i & stb_i & ~ack_o;
   assign wr     = wb_req & we_i;
   assign rd     = wb_req & ~we_i;
   always_comb begin
      rd_val = 16'h0;
      if (adr_i == `TWC_OFS_CTRL) begin
         rd_val = ctrl;
      end else if (adr_i == `TWC_OFS_STAT) begin
         rd_val[`TWC_S_RXF]   = rx_full;
         rd_val[`TWC_S_ACKS]  = ackstat;
         rd_val[`TWC_S_OVF]   = ovf;
         rd_val[`TWC_S_WCOL]  = wcol;
         rd_val[`TWC_S_MBUSY] = (m_st != twc_pkg::MST_IDLE) | tx_pend;
         rd_val[`TWC_S_BUSY]  = bus_busy;
         rd_val[`TWC_S_GC]    = gc_seen;
         rd_val[`TWC_S_TEN]   = ten_seen;
         rd_val[`TWC_S_SRD]   = (s_st == twc_pkg::SLV_TX) |
                                (s_st == twc_pkg::SLV_TACK);
      end else if (adr_i == `TWC_OFS_OWN) begin
         rd_val = {6'h0, own};
      end else if (adr_i == `TWC_OFS_MASK) begin
         rd_val = {6'h0, msk};
      end else if (adr_i == `TWC_OFS_RATE) begin
         rd_val = rate;
      end else if (adr_i == `TWC_OFS_TXD) begin
         rd_val = {8'h0, txd};
      end else if (adr_i == `TWC_OFS_RXD) begin
         rd_val = {8'h0, rxd};
      end else if (adr_i == `TWC_OFS_OPT) begin
         rd_val = {15'h0, repeater};
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'h0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= wb_req;
         if (rd) begin
            dat_o <= {16'h0, rd_val};
         end
      end
   end

   // Control register with hardware clears folded in
   always_comb begin
      next_ctrl = ctrl;
      if (wr && adr_i == `TWC_OFS_CTRL) begin
         next_ctrl = lane(ctrl, dat_i[15:0], sel_i) & `TWC_CTRL_WMASK;
      end
      if (m_fin) begin
         case (m_st)
            twc_pkg::MST_START:   next_ctrl[`TWC_B_SEN]   = 1'h0;
            twc_pkg::MST_RESTART: next_ctrl[`TWC_B_RESTART_GO]  = 1'h0;
            twc_pkg::MST_STOP:    next_ctrl[`TWC_B_PEN]   = 1'h0;
            twc_pkg::MST_ACK:     next_ctrl[`TWC_B_ACK_SEQ_GO] = 1'h0;
            twc_pkg::MST_RX:      next_ctrl[`TWC_B_MASTER_RX_GO]  = 1'h0;
            default: ;
         endcase
      end
      if (s_txbeg || (s_rxend && ctrl[`TWC_B_STR])) begin
         next_ctrl[`TWC_B_REL] = 1'h0;
      end
      if (!next_ctrl[`TWC_B_ON]) begin
         next_ctrl[`TWC_B_REL] = 1'h1;
         next_ctrl[`TWC_B_ACK_SEQ_GO:`TWC_B_SEN] = 5'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `TWC_CTRL_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         own      <= 10'h0;
         msk      <= 10'h0;
         rate     <= 16'h0;
         txd      <= 8'h0;
         repeater <= 1'h0;
      end else if (wr) begin
         if (adr_i == `TWC_OFS_OWN) begin
            own <= 10'(lane({6'h0, own}, dat_i[15:0], sel_i));
         end else if (adr_i == `TWC_OFS_MASK) begin
            msk <= 10'(lane({6'h0, msk}, dat_i[15:0], sel_i));
         end else if (adr_i == `TWC_OFS_RATE) begin
            rate <= lane(rate, dat_i[15:0], sel_i);
         end else if (adr_i == `TWC_OFS_TXD && sel_i[0]) begin
            txd <= dat_i[7:0];
         end else if (adr_i == `TWC_OFS_OPT && sel_i[0]) begin
            repeater <= dat_i[0];
         end
      end
   end

   // Status flags: hardware set wins over software clear
   always_ff @(posedge clk_i) begin
      if (rst_i || !ctrl[`TWC_B_ON]) begin
         rx_full  <= 1'h0;
         ovf      <= 1'h0;
         wcol     <= 1'h0;
         ackstat  <= 1'h0;
         bus_busy <= 1'h0;
         tx_pend  <= 1'h0;
         rxd      <= 8'h0;
      end else begin
         if (rd && adr_i == `TWC_OFS_RXD) begin
            rx_full <= 1'h0;
         end
         if (wr && adr_i == `TWC_OFS_STAT && sel_i[0]) begin
            ovf  <= ovf & ~dat_i[`TWC_S_OVF];
            wcol <= wcol & ~dat_i[`TWC_S_WCOL];
         end
         if (m_fin && m_st == twc_pkg::MST_RX) begin
            rxd     <= {m_sh[6:0], sda_s};
            rx_full <= 1'h1;
            if (rx_full) ovf <= 1'h1;
         end else if (s_rxend) begin
            rxd     <= s_sh;
            rx_full <= 1'h1;
            if (rx_full) ovf <= 1'h1;
         end
         if (m_fin && m_st == twc_pkg::MST_TX) begin
            ackstat <= sda_s;
         end else if (scl_rise && s_st == twc_pkg::SLV_TACK) begin
            ackstat <= sda_s;
         end
         if (start_det) begin
            bus_busy <= 1'h1;
         end else if (stop_det) begin
            bus_busy <= 1'h0;
         end
         if (m_go && m_nx == twc_pkg::MST_TX) begin
            tx_pend <= 1'h0;
         end else if (wr && adr_i == `TWC_OFS_TXD && m_own) begin
            if (m_st != twc_pkg::MST_IDLE || tx_pend) begin
               wcol <= 1'h1;
            end else begin
               tx_pend <= 1'h1;
            end
         end
      end
   end

   // Master: choose the next sequence from the go bits
   always_comb begin
      m_nx = twc_pkg::MST_IDLE;
      if (ctrl[`TWC_B_SEN] && !bus_busy && !m_own) begin
         m_nx = twc_pkg::MST_START;
      end else if (ctrl[`TWC_B_RESTART_GO] && m_own) begin
         m_nx = twc_pkg::MST_RESTART;
      end else if (ctrl[`TWC_B_PEN] && m_own) begin
         m_nx = twc_pkg::MST_STOP;
      end else if (ctrl[`TWC_B_MASTER_RX_GO] && m_own) begin
         m_nx = twc_pkg::MST_RX;
      end else if (ctrl[`TWC_B_ACK_SEQ_GO] && m_own) begin
         m_nx = twc_pkg::MST_ACK;
      end else if (tx_pend && m_own) begin
         m_nx = twc_pkg::MST_TX;
      end
      case (m_st)
         twc_pkg::MST_START:   m_last = m_step == 5'h1;
         twc_pkg::MST_RESTART: m_last = m_step == 5'h3;
         twc_pkg::MST_STOP:    m_last = m_step == 5'h2;
         twc_pkg::MST_TX:      m_last = m_step == `TWC_ST_TX_LAST;
         twc_pkg::MST_RX:      m_last = m_step == `TWC_ST_RX_LAST;
         twc_pkg::MST_ACK:     m_last = m_step == 5'h1;
         default:              m_last = 1'h0;
      endcase
   end
   assign m_go      = run && m_st == twc_pkg::MST_IDLE &&
                      m_nx != twc_pkg::MST_IDLE;
   assign m_fin     = dv.tick && m_last;
   assign dv.load   = m_go;
   assign dv.run    = run && m_st != twc_pkg::MST_IDLE;
   assign dv.reload = rate;

   // Each divider tick advances the master sequence one step
   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         m_st      <= twc_pkg::MST_IDLE;
         m_step    <= 5'h0;
         m_sh      <= 8'h0;
         m_scl_low <= 1'h0;
         m_sda_low <= 1'h0;
         m_own     <= 1'h0;
      end else if (m_go) begin
         m_st      <= m_nx;
         m_step    <= 5'h0;
         m_sh      <= txd;
         m_scl_low <= m_nx != twc_pkg::MST_START;
         case (m_nx)
            twc_pkg::MST_START: m_sda_low <= 1'h1;
            twc_pkg::MST_STOP:  m_sda_low <= 1'h1;
            twc_pkg::MST_TX:    m_sda_low <= ~txd[7];
            twc_pkg::MST_ACK:   m_sda_low <= ~ctrl[`TWC_B_ACKV];
            default:            m_sda_low <= 1'h0;
         endcase
      end else if (dv.tick) begin
         m_step <= m_step + 5'h1;
         case (m_st)
            twc_pkg::MST_START: m_scl_low <= 1'h1;
            twc_pkg::MST_RESTART: begin
               if (m_step == 5'h0) m_scl_low <= 1'h0;
               if (m_step == 5'h1) m_sda_low <= 1'h1;
               if (m_step == 5'h2) m_scl_low <= 1'h1;
            end
            twc_pkg::MST_STOP: begin
               if (m_step == 5'h0) m_scl_low <= 1'h0;
               if (m_step == 5'h1) m_sda_low <= 1'h0;
            end
            twc_pkg::MST_ACK: begin
               m_scl_low <= m_step != 5'h0;
            end
            twc_pkg::MST_TX, twc_pkg::MST_RX: begin
               m_scl_low <= m_step[0];
               if (m_step[0]) begin
                  m_sh <= {m_sh[6:0], sda_s};
                  if (m_st == twc_pkg::MST_TX) begin
                     m_sda_low <= (m_step != 5'h0F) & ~m_sh[6];
                  end
               end
            end
            default: ;
         endcase
         if (m_fin) begin
            m_st   <= twc_pkg::MST_IDLE;
            m_step <= 5'h0;
            if (m_st == twc_pkg::MST_ACK) m_sda_low <= 1'h0;
            if (m_st == twc_pkg::MST_START) m_own <= 1'h1;
            if (m_st == twc_pkg::MST_STOP) m_own <= 1'h0;
         end
      end
   end

   // Slave address acceptance
   assign s_a   = s_sh[7:1];
   assign gcall = s_a == 7'h00 && !s_sh[0];
   always_comb begin
      if (repeater) begin
         acc1 = 1'h1;
      end else if (ctrl[`TWC_B_TEN] && s_a[6:2] == 5'h1E) begin
         acc1 = meq({8'h0, s_a[1:0]}, {8'h0, own[9:8]}, {8'h0, msk[9:8]},
                    ctrl[`TWC_B_STRICT]) && (!s_sh[0] || s_pair);
      end else if (gcall) begin
         acc1 = ctrl[`TWC_B_GCA];
      end else if (rsv(s_a)) begin
         // Reserved: acked only when not strict, never as a masked hit
         acc1 = !ctrl[`TWC_B_STRICT] && s_a[6:2] != 5'h1E;
      end else begin
         acc1 = !ctrl[`TWC_B_TEN] && meq({3'h0, s_a}, {3'h0, own[6:0]},
                    {3'h0, msk[6:0]}, ctrl[`TWC_B_STRICT]);
      end
      acc2 = repeater || meq({2'h0, s_sh}, {2'h0, own[7:0]},
                             {2'h0, msk[7:0]}, ctrl[`TWC_B_STRICT]);
   end
   assign s_txbeg = scl_fall && ((s_st == twc_pkg::SLV_AACK && s_rw) ||
                    (s_st == twc_pkg::SLV_TACK && !s_nack));
   assign s_rxend = scl_fall && s_st == twc_pkg::SLV_RX && s_cnt == 4'h8;
   // Without stretch allow a zero holds at once; with it, at clock low
   assign s_scl_low = s_st != twc_pkg::SLV_IDLE && !ctrl[`TWC_B_REL] &&
                      (!ctrl[`TWC_B_STR] || !scl_s);
   assign s_sda_drv = s_st == twc_pkg::SLV_TX ? ~txd[3'h7 - s_cnt[2:0]]
                                              : s_sda_low;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run || m_own || stop_det) begin
         s_st      <= twc_pkg::SLV_IDLE;
         s_cnt     <= 4'h0;
         s_sh      <= 8'h0;
         s_sda_low <= 1'h0;
         s_rw      <= 1'h0;
         s_nack    <= 1'h0;
         s_pair    <= 1'h0;
         s_second  <= 1'h0;
         gc_seen   <= 1'h0;
         ten_seen  <= 1'h0;
      end else if (start_det) begin
         s_st  <= twc_pkg::SLV_ADDR;
         s_cnt <= 4'h0;
      end else if (scl_rise) begin
         if (s_st == twc_pkg::SLV_TACK) begin
            s_nack <= sda_s;
         end else if (s_st == twc_pkg::SLV_ADDR ||
                      s_st == twc_pkg::SLV_ADDR2 ||
                      s_st == twc_pkg::SLV_RX) begin
            s_sh  <= {s_sh[6:0], sda_s};
            s_cnt <= s_cnt + 4'h1;
         end
      end else if (scl_fall) begin
         case (s_st)
            twc_pkg::SLV_ADDR: if (s_cnt == 4'h8) begin
               s_st      <= acc1 ? twc_pkg::SLV_AACK : twc_pkg::SLV_IDLE;
               s_sda_low <= acc1;
               s_rw      <= s_sh[0];
               s_second  <= 1'h0;
               gc_seen   <= gc_seen | (acc1 & gcall);
            end
            twc_pkg::SLV_ADDR2: if (s_cnt == 4'h8) begin
               s_st      <= acc2 ? twc_pkg::SLV_AACK : twc_pkg::SLV_IDLE;
               s_sda_low <= acc2;
               s_pair    <= acc2;
               s_second  <= 1'h1;
               ten_seen  <= acc2;
            end
            twc_pkg::SLV_AACK: begin
               s_sda_low <= 1'h0;
               s_cnt     <= 4'h0;
               if (s_rw) begin
                  s_st <= twc_pkg::SLV_TX;
               end else if (ctrl[`TWC_B_TEN] && !s_second && !repeater) begin
                  s_st <= twc_pkg::SLV_ADDR2;
               end else begin
                  s_st <= twc_pkg::SLV_RX;
               end
            end
            twc_pkg::SLV_RX: if (s_cnt == 4'h8) begin
               s_st      <= twc_pkg::SLV_RACK;
               s_sda_low <= 1'h1;
            end
            twc_pkg::SLV_RACK: begin
               s_st      <= twc_pkg::SLV_RX;
               s_sda_low <= 1'h0;
               s_cnt     <= 4'h0;
            end
            twc_pkg::SLV_TX: begin
               s_cnt <= s_cnt + 4'h1;
               if (s_cnt == 4'h7) s_st <= twc_pkg::SLV_TACK;
            end
            twc_pkg::SLV_TACK: begin
               s_st  <= s_nack ? twc_pkg::SLV_IDLE : twc_pkg::SLV_TX;
               s_cnt <= 4'h0;
            end
            default: ;
         endcase
      end
   end

   // Open-drain pins: only ever pull low, released while off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_o        <= 1'h0;
         sda_o        <= 1'h0;
         scl_oe_n_o   <= 1'h1;
         sda_oe_n_o   <= 1'h1;
         pins_owned_o <= 1'h0;
         slew_off_o   <= 1'h0;
         smbus_lvl_o  <= 1'h0;
      end else begin
         scl_o        <= 1'h0;
         sda_o        <= 1'h0;
         scl_oe_n_o   <= ~(ctrl[`TWC_B_ON] & (m_scl_low | s_scl_low));
         sda_oe_n_o   <= ~(ctrl[`TWC_B_ON] &
                           (m_sda_low | (s_sda_drv & ~m_own)));
         pins_owned_o <= ctrl[`TWC_B_ON];
         slew_off_o   <= ctrl[`TWC_B_SLEW];
         smbus_lvl_o  <= ctrl[`TWC_B_SMB];
      end
   end
endmodule

// File: logic/twc_cfg.svh
// Register offsets, field positions and reset values of the two-wire block
`ifndef TWC_CFG_SVH
`define TWC_CFG_SVH
`define TWC_OFS_CTRL   8'h00
`define TWC_OFS_STAT   8'h04
`define TWC_OFS_OWN    8'h08
`define TWC_OFS_MASK   8'h0C
`define TWC_OFS_RATE   8'h10
`define TWC_OFS_TXD    8'h14
`define TWC_OFS_RXD    8'h18
`define TWC_OFS_OPT    8'h1C
`define TWC_CTRL_RST   16'h1000
`define TWC_CTRL_WMASK 16'hBFFF
`define TWC_B_ON       15
`define TWC_B_SIDL     13
`define TWC_B_REL      12
`define TWC_B_STRICT   11
`define TWC_B_TEN      10
`define TWC_B_SLEW     9
`define TWC_B_SMB      8
`define TWC_B_GCA      7
`define TWC_B_STR      6
`define TWC_B_ACKV     5
`define TWC_B_ACK_SEQ_GO    4
`define TWC_B_MASTER_RX_GO     3
`define TWC_B_PEN      2
`define TWC_B_RESTART_GO     1
`define TWC_B_SEN      0
`define TWC_S_RXF      0
`define TWC_S_ACKS     1
`define TWC_S_OVF      2
`define TWC_S_WCOL     3
`define TWC_S_MBUSY    4
`define TWC_S_BUSY     5
`define TWC_S_GC       6
`define TWC_S_TEN      7
`define TWC_S_SRD      8
`define TWC_ST_TX_LAST 5'h11
`define TWC_ST_RX_LAST 5'h0F
`endif

// File: logic/twc_pkg.sv
// State types of the two-wire controller
package twc_pkg;
   typedef enum logic [2:0] {
      MST_IDLE, MST_START, MST_RESTART, MST_STOP, MST_TX, MST_RX, MST_ACK
   } twc_mst_type;
   typedef enum logic [2:0] {
      SLV_IDLE, SLV_ADDR, SLV_ADDR2, SLV_AACK, SLV_RX, SLV_RACK, SLV_TX,
      SLV_TACK
   } twc_slv_type;
endpackage

// File: logic/twc_div_if.sv
// Link between the controller and its rate divider
`timescale 1ns/100ps
interface twc_div_if;
   logic        load;
   logic        run;
   logic [15:0] reload;
   logic        tick;
   modport ctl (output load, output run, output reload, input tick);
   modport div (input load, input run, input reload, output tick);
endinterface

// File: logic/twc_rate_div.sv
// Reloading down counter that paces the master clock phases
`timescale 1ns/100ps
module twc_rate_div (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Controller side
   twc_div_if.div   dv
);
   logic [16:0] cnt;

   // One phase lasts reload + 2 cycles: the load cycle plus reload + 1
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt     <= 17'h0;
         dv.tick <= 1'h0;
      end else if (dv.load) begin
         cnt     <= {1'h0, dv.reload} + 17'h1;
         dv.tick <= 1'h0;
      end else if (dv.run && cnt == 17'h0) begin
         cnt     <= {1'h0, dv.reload} + 17'h1;
         dv.tick <= 1'h1;
      end else if (dv.run) begin
         cnt     <= cnt - 17'h1;
         dv.tick <= 1'h0;
      end else begin
         dv.tick <= 1'h0;
      end
   end
endmodule

// File: test/twc_chk.sv
// Port assertions of the two-wire controller
`timescale 1ns/100ps
module twc_chk (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Register port
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // Pins and system
   input wire logic        scl_o,
   input wire logic        sda_o,
   input wire logic        scl_oe_n_o,
   input wire logic        sda_oe_n_o,
   input wire logic        pins_owned_o,
   input wire logic        slew_off_o,
   input wire logic        smbus_lvl_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req;
   logic wr_hi;
   assign req = cyc_i & stb_i & ~ack_o;
   assign wr_hi = req & we_i & (adr_i == 8'h00) & sel_i[1];
   a_ack_timely: assert property (req |=> ack_o) else $error("ack late");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack long");
   a_unmapped_zero: assert property (
      req && !we_i && adr_i == 8'h40 |=> dat_o == 32'h0
   ) else $error("unmapped read not zero");
   a_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0)
      else $error("upper read bits set");
   a_open_drain: assert property (!scl_o && !sda_o)
      else $error("pin driven high");
   a_off_released: assert property (
      !pins_owned_o [*3] |-> scl_oe_n_o && sda_oe_n_o
   ) else $error("pins pulled while off");
   a_owned_follows: assert property (
      wr_hi |-> ##2 pins_owned_o == $past(dat_i[15], 2)
   ) else $error("owned output wrong");
   a_slew_follows: assert property (
      wr_hi |-> ##2 slew_off_o == $past(dat_i[9], 2)
   ) else $error("slew output wrong");
   a_level_follows: assert property (
      wr_hi |-> ##2 smbus_lvl_o == $past(dat_i[8], 2)
   ) else $error("level output wrong");
   c_write: cover property (wr_hi);
   c_data_low: cover property (pins_owned_o && !sda_oe_n_o);
   c_clock_low: cover property (pins_owned_o && !scl_oe_n_o);
endmodule
bind twc_top twc_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .scl_o(scl_o), .sda_o(sda_o),
   .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o),
   .pins_owned_o(pins_owned_o), .slew_off_o(slew_off_o),
   .smbus_lvl_o(smbus_lvl_o));

// File: test/twc_peer.sv
// Outside bus party: pull-ups and a simple controlling device
`timescale 1ns/100ps
module twc_peer (
   // Clock
   input wire logic clk_i,
   // Lines
   input wire logic scl_oe_n_i,
   input wire logic sda_oe_n_i,
   output logic     scl_o,
   output logic     sda_o
);
   localparam int Q = 16;
   logic scl_d = 1'b1;
   logic sda_d = 1'b1;
   // Pull-ups: a line nobody pulls reads high
   assign scl_o = scl_oe_n_i & scl_d;
   assign sda_o = sda_oe_n_i & sda_d;
   task automatic step(input logic s, input logic d);
      scl_d <= s;
      sda_d <= d;
      repeat (Q / 2) @(posedge clk_i);
   endtask
   // Start, address byte, acknowledge sample, stop
   task automatic addr_cycle(input logic [7:0] b, output logic ack);
      step(1, 0);
      for (int i = 7; i >= 0; i--) begin
         step(0, sda_d);
         step(0, b[i]);
         step(1, b[i]);
         step(1, b[i]);
      end
      step(0, b[0]);
      step(0, 1);
      step(1, 1);
      ack = ~sda_o;
      step(1, 1);
      step(0, 1);
      step(0, 0);
      step(1, 0);
      step(1, 1);
   endtask
endmodule

// File: test/twc_top_bench.sv
// Self-checking bench of the two-wire controller
`timescale 1ns/100ps
module twc_top_bench;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic        idle_i = 0, ack_o, scl, sda, scl_o, sda_o, ack;
   logic        scl_oe_n_o, sda_oe_n_o, own_o, slew_o, smb_o;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   int          error_cnt = 0, cmp_count = 0;
   time         t0;
   initial forever #2 clk_i = ~clk_i;
   twc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .scl_i(scl), .sda_i(sda), .scl_o(scl_o),
      .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
      .idle_i(idle_i), .pins_owned_o(own_o), .slew_off_o(slew_o),
      .smbus_lvl_o(smb_o));
   twc_peer i_peer (.clk_i(clk_i), .scl_oe_n_i(scl_oe_n_o),
      .sda_oe_n_i(sda_oe_n_o), .scl_o(scl), .sda_o(sda));
   task automatic cmp(input string what, input logic [31:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic poll(input logic [31:0] m);
      int n = 0;
      do begin
         wb(0, 8'h00, 0);
         n++;
      end while ((rd & m) !== 0 && n < 100);
      cmp("go bit", 32'h0, rd & m);
   endtask
   task automatic acase(input logic [15:0] c, input logic [9:0] own, m,
                        input logic [7:0] b, input logic e);
      wb(1, 8'h08, own);
      wb(1, 8'h0C, m);
      wb(1, 8'h00, c);
      i_peer.addr_cycle(b, ack);
      cmp("slave ack", e, ack);
   endtask
   task automatic t_regs;
      wb(0, 8'h00, 0);
      cmp("ctrl reset", 32'h1000, rd);
      wb(0, 8'h40, 0);
      cmp("unmapped", 32'h0, rd);
      wb(1, 8'h00, 32'h8300);
      repeat (2) @(posedge clk_i);
      cmp("outputs on", 3'b111, {own_o, slew_o, smb_o});
      wb(0, 8'h00, 0);
      cmp("release written", 32'h8300, rd);
      wb(1, 8'h00, 32'h0);
      wb(0, 8'h00, 0);
      cmp("release forced", 32'h1000, rd);
      cmp("outputs off", 3'b000, {own_o, slew_o, smb_o});
      $display("t_regs done");
   endtask
   task automatic t_rate;
      wb(1, 8'h10, 32'h3);
      wb(1, 8'h00, 32'h9001);
      poll(32'h1);
      wb(1, 8'h14, 32'hA5);
      @(posedge scl_oe_n_o);
      t0 = $time;
      @(posedge scl_oe_n_o);
      cmp("clock period", 2 * (3 + 2), ($time - t0) / 4);
      repeat (200) @(posedge clk_i);
      wb(1, 8'h00, 32'h9008);
      poll(32'h8);
      wb(0, 8'h18, 0);
      cmp("rx byte", 32'hFF, rd);
      wb(1, 8'h00, 32'h9010);
      @(posedge clk_i);
      cmp("ack drive", 32'h0, sda_oe_n_o);
      poll(32'h10);
      wb(1, 8'h00, 32'h9004);
      poll(32'h4);
      wb(1, 8'h00, 32'h0);
      $display("t_rate done");
   endtask
   task automatic t_addr;
      acase(16'h9000, 10'h050, 10'h000, 8'hA0, 1);
      acase(16'h9000, 10'h050, 10'h000, 8'hA2, 0);
      acase(16'h9000, 10'h050, 10'h001, 8'hA2, 1);
      acase(16'h9800, 10'h050, 10'h001, 8'hA2, 0);
      acase(16'h9000, 10'h050, 10'h000, 8'h00, 0);
      acase(16'h9080, 10'h050, 10'h000, 8'h00, 1);
      acase(16'h9800, 10'h050, 10'h000, 8'h08, 0);
      acase(16'h9000, 10'h050, 10'h000, 8'h08, 1);
      acase(16'h9000, 10'h350, 10'h000, 8'hF6, 0);
      acase(16'h9400, 10'h350, 10'h000, 8'hF6, 1);
      wb(1, 8'h1C, 32'h1);
      acase(16'h9000, 10'h050, 10'h000, 8'h66, 1);
      wb(1, 8'h1C, 32'h0);
      idle_i <= 1;
      acase(16'hB000, 10'h050, 10'h000, 8'hA0, 0);
      idle_i <= 0;
      $display("t_addr done");
   endtask
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Whole run is about five thousand cycles; this allows five times that
   initial begin
      #100000;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      t_regs;
      t_rate;
      t_addr;
      report_and_stop;
   end
endmodule
